// file: src/twp_pot_slave.sv
`include "twp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module twp_pot_slave
    import twp_pkg::*;
#(
    parameter int NV_WRITE_CYCLES = `TWP_NV_WRITE_US * `TWP_CLK_MHZ,
    parameter int TAPS            = 1024
) (
    input  wire logic            clock,         // 25 MHz system clock
    input  wire logic            rst,           // Sync reset, active high
    input  wire logic            scl_in,        // Serial clock pin
    input  wire logic            sda_in,        // Serial data pin level
    output logic                 sda_out,       // Always low when driven
    output logic                 sda_oe,        // High pulls data line low
    input  wire logic            address_pin_high, // Address pin 1
    input  wire logic            address_pin_low,  // Address pin 0
    input  wire logic            write_protect_n,  // Low blocks nonvolatile writes
    output logic                 nv_busy,       // Internal write in progress
    output logic [9:0]           wiper_position,// Current wiper register
    output logic [TAPS-1:0]      tap_on         // One-hot tap switches
);
    if (NV_WRITE_CYCLES < 1 || NV_WRITE_CYCLES > `TWP_NV_MAX_US * `TWP_CLK_MHZ) begin : g_bad_nv
        $error("nonvolatile write time out of range");
    end

    function automatic logic agree(input logic [2:0] s);
        agree = (s[1] == s[2]);
    endfunction : agree

    // Instruction set pairs; wiper ops need a zero pointer
    function automatic logic instr_known(input logic rd, input logic [7:0] ins);
        case ({rd, ins[7:5]})
            {1'b1, `TWP_OP_RD_WIPER},
            {1'b0, `TWP_OP_WR_WIPER}:   instr_known = (ins[3:2] == 2'h0);
            {1'b1, `TWP_OP_RD_STORED},
            {1'b0, `TWP_OP_WR_STORED},
            {1'b1, `TWP_OP_COPY_TO_WP},
            {1'b0, `TWP_OP_COPY_TO_ST}: instr_known = 1'b1;
            default:                    instr_known = 1'b0;
        endcase
    endfunction : instr_known

    // First read byte carries bits 9:8 at its bottom, the rest released
    function automatic logic tx_bit(input logic [9:0] w, input logic hi, input logic [2:0] idx);
        if (hi) tx_bit = (idx == 3'h1) ? w[9] : ((idx == 3'h0) ? w[8] : 1'b1);
        else    tx_bit = w[idx];
    endfunction : tx_bit

    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic        scl_q;
    logic        sda_q;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;

    // Three-stage sync; a level counts once stages two and three agree
    always_ff @(posedge clock) begin
        if (rst) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            if (agree(scl_s)) scl_q <= scl_s[2];
            if (agree(sda_s)) sda_q <= sda_s[2];
        end
    end

    logic scl_new;
    logic sda_new;
    assign scl_new   = agree(scl_s) ? scl_s[2] : scl_q;
    assign sda_new   = agree(sda_s) ? sda_s[2] : sda_q;
    assign scl_rise  = !scl_q && scl_new;
    assign scl_fall  = scl_q && !scl_new;
    assign start_det = scl_q && scl_new && sda_q && !sda_new;
    assign stop_det  = scl_q && scl_new && !sda_q && sda_new;

    twp_state_t  state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic        ack_phase;
    logic        dir_read;
    logic [2:0]  opcode;
    logic [1:0]  pointer;
    logic        data_hi;
    logic [9:0]  stored [4];
    logic [9:0]  out_word;
    logic        nv_pending;
    logic [1:0]  nv_ptr;
    logic [9:0]  nv_value;
    logic [31:0] nv_cnt;
    logic        wiper_load;
    logic        powerup;

    twp_tap_if tap_bus();
    assign tap_bus.position = wiper_position;
    assign tap_bus.load     = wiper_load;

    twp_tap_decoder #(.TAPS(TAPS)) u_taps (
        .clock  (clock),
        .rst    (rst),
        .tap    (tap_bus),
        .tap_on (tap_on)
    );

    logic addr_ok;
    assign addr_ok = (shreg[7:4] == `TWP_TYPE_ID)
                  && (shreg[2] == address_pin_high)
                  && (shreg[1] == address_pin_low);

    logic [7:0] byte_in;
    assign byte_in = {shreg[6:0], sda_new};

    // Serial protocol engine
    always_ff @(posedge clock) begin
        if (rst) begin
            state      <= TWP_IDLE;
            bit_cnt    <= 4'h0;
            shreg      <= 8'h00;
            ack_phase  <= 1'b0;
            dir_read   <= 1'b0;
            opcode     <= 3'h0;
            pointer    <= 2'h0;
            data_hi    <= 1'b0;
            out_word   <= 10'h000;
            sda_out    <= 1'b0;
            sda_oe     <= 1'b0;
        end else if (start_det && !nv_busy) begin
            state     <= TWP_ADDR;
            bit_cnt   <= 4'h0;
            ack_phase <= 1'b0;
            sda_oe    <= 1'b0;
        end else if (start_det) begin
            state     <= TWP_ADDR;
            bit_cnt   <= 4'h0;
            ack_phase <= 1'b0;
            sda_oe    <= 1'b0;
        end else if (stop_det) begin
            state  <= TWP_IDLE;
            sda_oe <= 1'b0;
        end else if (state == TWP_WAIT) begin
            // An ack given on entry must still be let go, or stop is masked
            if (scl_fall) sda_oe <= 1'b0;
        end else if (state != TWP_IDLE) begin
            if (scl_rise && !ack_phase && state != TWP_SEND) begin
                shreg   <= byte_in;
                bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_rise && state == TWP_SEND && ack_phase) begin
                // Master nack ends read data
                if (sda_new) state <= TWP_WAIT;
            end else if (scl_fall && ack_phase) begin
                ack_phase <= 1'b0;
                bit_cnt   <= 4'h0;
                sda_oe    <= 1'b0;
                if (state == TWP_SEND) begin
                    sda_oe  <= !tx_bit(out_word, data_hi, 3'h7);
                    bit_cnt <= 4'h1;
                end
            end else if (scl_fall && state == TWP_SEND) begin
                if (bit_cnt == 4'h8) begin
                    sda_oe    <= 1'b0;
                    ack_phase <= 1'b1;
                    data_hi   <= 1'b0;
                end else begin
                    sda_oe  <= !tx_bit(out_word, data_hi, 3'h7 - bit_cnt[2:0]);
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end else if (scl_fall && bit_cnt == 4'h8) begin
                ack_phase <= 1'b1;
                case (state)
                    TWP_ADDR: begin
                        dir_read <= shreg[0];
                        if (addr_ok && !nv_busy) begin
                            sda_oe <= 1'b1;
                            state  <= TWP_INSTR;
                        end else begin
                            state  <= TWP_WAIT;
                        end
                    end
                    TWP_INSTR: begin
                        opcode  <= shreg[7:5];
                        pointer <= shreg[3:2];
                        sda_oe  <= instr_known(dir_read, shreg);
                        data_hi <= 1'b1;
                        if (!instr_known(dir_read, shreg)) begin
                            state <= TWP_WAIT;
                        end else if (dir_read && shreg[7:5] == `TWP_OP_RD_WIPER) begin
                            state    <= TWP_SEND;
                            out_word <= wiper_position;
                        end else if (dir_read && shreg[7:5] == `TWP_OP_RD_STORED) begin
                            state    <= TWP_SEND;
                            out_word <= stored[shreg[3:2]];
                        end else if (!dir_read && shreg[7:5] != `TWP_OP_COPY_TO_ST) begin
                            state <= TWP_DATA;
                        end else begin
                            // Copies act at this ack and take no data byte
                            state <= TWP_WAIT;
                        end
                    end
                    TWP_DATA: begin
                        sda_oe  <= 1'b1;
                        data_hi <= !data_hi;
                    end
                    default: state <= TWP_WAIT;
                endcase
            end
        end
    end

    // Data byte capture and register effects
    logic [9:0] rx_word;
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_word        <= 10'h000;
            wiper_position <= 10'h000;
            wiper_load     <= 1'b0;
            powerup        <= 1'b1;
            nv_pending     <= 1'b0;
            nv_ptr         <= 2'h0;
            nv_value       <= 10'h000;
        end else begin
            wiper_load <= 1'b0;
            powerup    <= 1'b0;
            if (powerup) begin
                wiper_position <= stored[0];
                wiper_load     <= 1'b1;
            end
            if (scl_fall && bit_cnt == 4'h8 && !ack_phase && state == TWP_DATA) begin
                if (data_hi) begin
                    rx_word[9:8] <= shreg[1:0];
                end else begin
                    rx_word[7:0] <= shreg;
                    if (opcode == `TWP_OP_WR_WIPER) begin
                        wiper_position <= {rx_word[9:8], shreg};
                        wiper_load     <= 1'b1;
                    end else begin
                        nv_pending <= write_protect_n;
                        nv_ptr     <= pointer;
                        nv_value   <= {rx_word[9:8], shreg};
                    end
                end
            end
            if (scl_fall && bit_cnt == 4'h8 && !ack_phase && state == TWP_INSTR) begin
                if (dir_read && shreg[7:5] == `TWP_OP_COPY_TO_WP) begin
                    wiper_position <= stored[shreg[3:2]];
                    wiper_load     <= 1'b1;
                end else if (!dir_read && shreg[7:5] == `TWP_OP_COPY_TO_ST) begin
                    nv_pending <= write_protect_n;
                    nv_ptr     <= shreg[3:2];
                    nv_value   <= wiper_position;
                end
            end
            if (start_det || (stop_det && nv_pending)) nv_pending <= 1'b0;
        end
    end

    // Internal nonvolatile write timer
    always_ff @(posedge clock) begin
        if (rst) begin
            nv_busy <= 1'b0;
            nv_cnt  <= 32'h0;
            for (int i = 0; i < 4; i++) stored[i] <= `TWP_STORED_RESET;
        end else if (nv_busy) begin
            if (nv_cnt == 32'(NV_WRITE_CYCLES - 1)) begin
                nv_busy        <= 1'b0;
                stored[nv_ptr] <= nv_value;
            end else begin
                nv_cnt <= nv_cnt + 32'h1;
            end
        end else if (stop_det && nv_pending) begin
            nv_busy <= 1'b1;
            nv_cnt  <= 32'h0;
        end
    end
endmodule : twp_pot_slave
`default_nettype wire

// file: src/twp_consts.svh
`ifndef TWP_CONSTS_SVH
`define TWP_CONSTS_SVH
`define TWP_TYPE_ID        4'h9   // Arbitrary type identifier value
`define TWP_OP_RD_WIPER    3'h4
`define TWP_OP_WR_WIPER    3'h5
`define TWP_OP_RD_STORED   3'h5
`define TWP_OP_WR_STORED   3'h6
`define TWP_OP_COPY_TO_WP  3'h6
`define TWP_OP_COPY_TO_ST  3'h7
`define TWP_CLK_MHZ        25
`define TWP_NV_WRITE_US    5000
`define TWP_NV_MAX_US      10000
`define TWP_STORED_RESET   10'h000
`endif

// file: src/twp_pkg.sv
package twp_pkg;
    typedef enum logic [2:0] {
        TWP_IDLE  = 3'b000,
        TWP_ADDR  = 3'b001,
        TWP_INSTR = 3'b010,
        TWP_DATA  = 3'b011,
        TWP_SEND  = 3'b100,
        TWP_WAIT  = 3'b101
    } twp_state_t;
endpackage : twp_pkg

// file: src/twp_tap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface twp_tap_if;
    logic [9:0] position;
    logic       load;
    modport src (output position, output load);
    modport dst (input position, input load);
endinterface : twp_tap_if
`default_nettype wire

// file: src/twp_tap_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module twp_tap_decoder #(
    parameter int TAPS = 1024
) (
    input  wire logic      clock,   // System clock
    input  wire logic      rst,     // Sync reset
    twp_tap_if.dst         tap,     // Position from command logic
    output logic [TAPS-1:0] tap_on  // One-hot switch enables
);
    if (TAPS != 1024) begin : g_bad_taps
        $error("tap count must be 1024");
    end

    logic break_cycle;

    // Break before make: one cycle all off between positions
    always_ff @(posedge clock) begin
        if (rst) begin
            tap_on      <= '0;
            break_cycle <= 1'b1;
        end else if (tap.load && !tap_on[tap.position]) begin
            // Reload of the lit position keeps its tap on
            tap_on      <= '0;
            break_cycle <= 1'b1;
        end else if (break_cycle) begin
            tap_on      <= TAPS'(1) << tap.position;
            break_cycle <= 1'b0;
        end
    end
endmodule : twp_tap_decoder
`default_nettype wire

// file: tb/twp_pot_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module twp_pot_monitor #(
    parameter int NV_WRITE_CYCLES = 125000,
    parameter int TAPS            = 1024
) (
    input wire logic            clock,            // Clock
    input wire logic            rst,              // Reset
    input wire logic            scl_in,           // Bus clock
    input wire logic            sda_in,           // Bus data
    input wire logic            sda_out,          // Drive value
    input wire logic            sda_oe,           // Drive enable
    input wire logic            address_pin_high, // Pin 1
    input wire logic            address_pin_low,  // Pin 0
    input wire logic            write_protect_n,  // Protect
    input wire logic            nv_busy,          // Write running
    input wire logic [9:0]      wiper_position,   // Wiper
    input wire logic [TAPS-1:0] tap_on            // Taps
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic       in_frame;
    logic [3:0] since_stop;
    int         busy_len;
    always_ff @(posedge clock) begin
        if (rst || (scl_in && $rose(sda_in))) begin
            in_frame <= 1'h0;
        end else if (scl_in && $fell(sda_in)) begin
            in_frame <= 1'h1;
        end
    end
    // Saturates so a long idle cannot wrap into a false recent stop
    always_ff @(posedge clock) begin
        if (rst || (scl_in && $rose(sda_in))) begin
            since_stop <= 4'h0;
        end else if (since_stop != 4'hf) begin
            since_stop <= since_stop + 4'h1;
        end
    end
    always_ff @(posedge clock) begin
        busy_len <= (rst || !nv_busy) ? 0 : busy_len + 1;
    end
    a_tap_single: assert property ($onehot0(tap_on)) else $error("two taps on");
    a_tap_follows: assert property ($stable(wiper_position) [*6] |-> tap_on[wiper_position] && $onehot(tap_on))
        else $error("tap does not match wiper");
    a_oe_after_fall: assert property ($changed(sda_oe) |-> !$past(scl_in, 2)) else $error("drive moved, clock high");
    a_drive_low: assert property (sda_oe |-> !sda_out) else $error("data driven high");
    a_busy_span: assert property ($fell(nv_busy) |-> busy_len >= NV_WRITE_CYCLES - 1 &&
        busy_len <= NV_WRITE_CYCLES + 1) else $error("write period length wrong");
    a_busy_silent: assert property (nv_busy |-> !sda_oe) else $error("answer while busy");
    a_busy_from_stop: assert property ($rose(nv_busy) |-> since_stop <= 4'h8) else $error("busy without stop");
    a_wp_blocks: assert property ($rose(nv_busy) |-> write_protect_n) else $error("write while protected");
    a_ack_framed: assert property ($rose(sda_oe) |-> in_frame) else $error("answer outside frame");
    c_busy: cover property ($fell(nv_busy));
    c_ack: cover property ($rose(sda_oe));
    c_move: cover property ($changed(wiper_position));
endmodule : twp_pot_monitor
bind twp_pot_slave twp_pot_monitor #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES), .TAPS(TAPS)) mon_u (
    .clock(clock), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_pin_high(address_pin_high), .address_pin_low(address_pin_low), .write_protect_n(write_protect_n),
    .nv_busy(nv_busy), .wiper_position(wiper_position), .tap_on(tap_on));
`default_nettype wire

// file: tb/twp_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module twp_bus_master (
    output logic     scl,     // Bus clock
    output logic     sda_low, // Pulls data low
    input wire logic sda      // Wire level
);
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    // Data moves well inside the low phase: the slave sees both pins through synchronisers
    task automatic cyc(input logic a, input logic b, input logic fall, output logic r);
        #100;
        sda_low = a;
        #100;
        scl = 1'h1;
        #60;
        sda_low = b;
        r = sda;
        #60;
        scl = fall ? 1'h0 : 1'h1;
    endtask : cyc
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            cyc(!tx[i], !tx[i], 1'h1, rx[i]);
        end
    endtask : xfer
endmodule : twp_bus_master
`default_nettype wire

// file: tb/two_wire_pot_command_slave_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "twp_consts.svh"
module two_wire_pot_command_slave_bench;
    localparam int NV = 200;
    logic          clock = 1'h0;
    logic          rst = 1'h1;
    logic          a_hi = 1'h0;
    logic          a_lo = 1'h0;
    logic          wp_n = 1'h1;
    logic          m_low, scl, sda_oe, sda_out, nv_busy;
    logic [9:0]    wiper;
    logic [1023:0] tap_on;
    logic [9:0]    st [4];
    int            n_fail = 0;
    int            cmp_count = 0;
    int            cycles = 0;
    int            seed = 16;
    wire           sda = !(m_low || (sda_oe && !sda_out));
    always #20 clock = ~clock;
    twp_pot_slave #(.NV_WRITE_CYCLES(NV), .TAPS(1024)) dut_u (
        .clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .address_pin_high(a_hi), .address_pin_low(a_lo), .write_protect_n(wp_n),
        .nv_busy(nv_busy), .wiper_position(wiper), .tap_on(tap_on));
    twp_bus_master m (.scl(scl), .sda_low(m_low), .sda(sda));
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic tap_chk(input logic [9:0] v);
        check("tap count", 10'($countones(tap_on)), 10'h1);
        check("tap select", {9'h0, tap_on[v]}, 10'h1);
    endtask : tap_chk
    // Data bytes are sent whenever n > 0, so a refused address is also shown to stay inert
    task automatic cmd(input logic [7:0] amask, input logic rw, input logic [7:0] ins, input int n,
                       input logic [9:0] wd, output int acks, output logic [9:0] rd);
        logic [8:0] r0;
        logic [8:0] r1;
        logic       k;
        m.cyc(1'h0, 1'h1, 1'h1, k);
        m.xfer({{`TWP_TYPE_ID, 1'h0, a_hi, a_lo, rw} ^ amask, 1'h1}, r0);
        m.xfer({ins, 1'h1}, r1);
        acks = !r0[0] + !r1[0];
        if (n > 0) begin
            m.xfer(rw ? 9'h1fe : {6'h0, wd[9:8], 1'h1}, r0);
            m.xfer(rw ? 9'h1ff : {wd[7:0], 1'h1}, r1);
            acks += rw ? 0 : !r0[0] + !r1[0];
            rd = {r0[2:1], r1[8:1]};
        end
        m.cyc(1'h1, 1'h0, 1'h0, k);
        repeat (8) @(posedge clock);
        #1;
    endtask : cmd
    task automatic poll(output int nacks);
        logic [8:0] r;
        logic       k;
        nacks = 0;
        r = 9'h1;
        while (r[0] && nacks < 40) begin
            m.cyc(1'h0, 1'h1, 1'h1, k);
            m.xfer({`TWP_TYPE_ID, 1'h0, a_hi, a_lo, 1'h0, 1'h1}, r);
            m.cyc(1'h1, 1'h0, 1'h0, k);
            nacks += r[0];
        end
    endtask : poll
    initial begin
        logic [9:0] v;
        logic [9:0] rd;
        int         acks;
        int         nacks;
        logic [1:0] p;
        logic [1:0] q;
        logic [7:0] bad [5] = '{8'h02, 8'h04, 8'h06, 8'h10, 8'h80};
        logic [8:0] odd [3] = '{9'h080, 9'h1e0, 9'h000};
        repeat (16) @(posedge clock);
        rst <= 1'h0;
        a_hi <= 1'($random(seed));
        a_lo <= 1'($random(seed));
        repeat (8) @(posedge clock);
        #1;
        check("wiper at reset", wiper, 10'h0);
        tap_chk(10'h0);
        st = '{default: 10'h0};
        for (int i = 0; i < 4; i++) begin
            p = 2'(i);
            q = p + 2'h1;
            v = 10'($random(seed));
            cmd(8'h0, 1'h0, {3'h6, 1'h0, p, 2'h0}, 2, v, acks, rd);
            check("stored write acks", 10'(acks), 10'h4);
            poll(nacks);
            check("poll refused", 10'(nacks > 0), 10'h1);
            st[p] = v;
            v = (i == 0) ? 10'h3ff : 10'($random(seed));
            cmd(8'h0, 1'h0, 8'ha0, 2, v, acks, rd);
            check("wiper write", wiper, v);
            tap_chk(v);
            cmd(8'h0, 1'h1, 8'h80, 2, 10'h0, acks, rd);
            check("wiper read", rd, v);
            check("read acks", 10'(acks), 10'h2);
            cmd(8'h0, 1'h0, {3'h7, 1'h0, q, 2'h0}, 0, 10'h0, acks, rd);
            poll(nacks);
            st[q] = v;
            cmd(8'h0, 1'h1, {3'h5, 1'h0, q, 2'h0}, 2, 10'h0, acks, rd);
            check("copied to stored", rd, st[q]);
            cmd(8'h0, 1'h1, {3'h6, 1'h0, p, 2'h0}, 0, 10'h0, acks, rd);
            check("copied to wiper", wiper, st[p]);
        end
        $display("register traffic done");
        foreach (bad[j]) begin
            cmd(bad[j], 1'h0, 8'ha0, 2, ~st[3], acks, rd);
            check("foreign address acks", 10'(acks), 10'h0);
        end
        foreach (odd[j]) begin
            cmd(8'h0, odd[j][8], odd[j][7:0], 0, 10'h0, acks, rd);
            check("unknown opcode acks", 10'(acks), 10'h1);
        end
        check("wiper kept", wiper, st[3]);
        $display("refusal traffic done");
        @(posedge clock);
        wp_n <= 1'h0;
        #1;
        cmd(8'h0, 1'h0, 8'hc0, 2, ~st[0], acks, rd);
        check("busy under protect", {9'h0, nv_busy}, 10'h0);
        @(posedge clock);
        wp_n <= 1'h1;
        #1;
        cmd(8'h0, 1'h1, 8'ha0, 2, 10'h0, acks, rd);
        check("protected value", rd, st[0]);
        $display("protect traffic done");
        conclude();
    end
endmodule : two_wire_pot_command_slave_bench
`default_nettype wire
